// *** design/sflash_host_ctrl.sv ***
module sflash_host_ctrl import sflash_host_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic req_in,
	input wire logic [7:0] opcode_in,
	input wire logic [23:0] addr_in,
	input wire logic [7:0] mode_in,
	input wire logic [15:0] len_in,
	input wire logic [7:0] wr_data_in,
	output logic ready_out,
	output logic wr_take_out,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	output logic done_out,
	output logic reject_out,
	output logic quad_mode_out,
	output logic cs_n_out,
	output logic sclk_out,
	output logic [3:0] sio_out,
	output logic [3:0] sio_oe_out,
	input wire logic [3:0] sio_in
);

	state_t state_q;
	phase_t phase_q;
	dir_t dir_q;
	logic [2:0] div_q;
	logic [2:0] bitc_q;
	logic [2:0] bits_q;
	logic [1:0] gap_q;
	logic [15:0] cnt_q;
	logic [15:0] len_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] op_q;
	logic [7:0] mode_q;
	logic [23:0] addr_q;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [1:0] n_addr_q;
	logic [1:0] n_dummy_q;
	logic has_mode_q;
	logic needs_latch_q;
	logic [2:0] aw_q;
	logic [2:0] dw_q;
	logic write_latch_flag_q;
	logic dpd_q;
	logic arm_q;
	logic f_known;
	logic f_latch;
	logic f_mode;
	logic [1:0] f_n_addr;
	logic [1:0] f_n_dummy;
	dir_t f_dir;
	logic [2:0] f_aw;
	logic [2:0] f_dw;

	sflash_op_format u_fmt (
		.opcode_in(opcode_in),
		.known_out(f_known),
		.needs_latch_out(f_latch),
		.has_mode_out(f_mode),
		.n_addr_out(f_n_addr),
		.n_dummy_out(f_n_dummy),
		.dir_out(f_dir),
		.addr_w_out(f_aw),
		.data_w_out(f_dw)
	);

	// lanes used by a phase
	function automatic logic [2:0] width_of(input phase_t p, input logic q,
			input logic [2:0] aw, input logic [2:0] dw);
		if (q)
			return W4;
		if (p == PH_OP)
			return W1;
		if (p == PH_DATA)
			return dw;
		return aw;
	endfunction

	// {enables, levels} for the top bits of a byte
	function automatic logic [7:0] pins(input logic [7:0] b,
			input logic [2:0] w, input logic drv);
		if (w == W4)
			return drv ? {4'hF, b[7:4]} : 8'h00;
		if (w == W2)
			return drv ? {4'hF, 2'h3, b[7:6]} : 8'hCC;
		return {4'hD, 3'h6, b[7]};
	endfunction

	// request checks before a frame opens
	wire logic bare_rdp = opcode_in == OP_RDP && len_in == 16'h0000;
	wire logic refuse = !f_known ||
		(dpd_q && opcode_in != OP_RDP) ||
		(f_latch && !write_latch_flag_q) ||
		(opcode_in == OP_RST && !arm_q) ||
		(f_dir == DIR_WRITE && len_in == 16'h0000);
	wire logic start = state_q == ST_IDLE && req_in && !refuse;

	// clock edge strobes
	wire logic tick = div_q == 3'(SCLK_HALF_CYC - 1);
	wire logic rise = state_q == ST_SHIFT && tick && !sclk_out;
	wire logic fall = state_q == ST_SHIFT && tick && sclk_out;
	wire logic [2:0] cur_w = width_of(phase_q, quad_mode_out, aw_q, dw_q);
	wire logic last_clk = (cur_w == W4) ? bitc_q == 3'h1 :
		(cur_w == W2) ? bitc_q == 3'h3 : bitc_q == 3'h7;
	wire logic byte_end = fall && last_clk;

	// phase sequencing
	wire logic has_data = dir_q != DIR_NONE && len_q != 16'h0000;
	wire logic [15:0] cnt_inc = cnt_q + 16'h0001;
	wire logic [15:0] phase_len = (phase_q == PH_ADDR) ? {14'h0000, n_addr_q} :
		(phase_q == PH_DUMMY) ? {14'h0000, n_dummy_q} :
		(phase_q == PH_DATA) ? len_q : 16'h0001;
	wire logic byte_last = cnt_inc == phase_len;
	phase_t after_dummy;
	phase_t after_mode;
	phase_t after_addr;
	phase_t after_cur;
	phase_t nxt_phase;
	assign after_dummy = has_data ? PH_DATA : PH_END;
	assign after_mode = (n_dummy_q != 2'h0) ? PH_DUMMY : after_dummy;
	assign after_addr = has_mode_q ? PH_MODE : after_mode;
	assign after_cur = (phase_q == PH_OP) ?
		((n_addr_q != 2'h0) ? PH_ADDR : after_addr) :
		(phase_q == PH_ADDR) ? after_addr :
		(phase_q == PH_MODE) ? after_mode :
		(phase_q == PH_DUMMY) ? after_dummy : PH_END;
	assign nxt_phase = byte_last ? after_cur : phase_q;
	wire logic [15:0] nxt_cnt = byte_last ? 16'h0000 : cnt_inc;
	wire logic frame_end = byte_end && nxt_phase == PH_END;

	// next byte to shift and its pin pattern
	wire logic [7:0] addr_byte = (nxt_cnt == 16'h0000) ? addr_q[23:16] :
		(nxt_cnt == 16'h0001) ? addr_q[15:8] : addr_q[7:0];
	wire logic [7:0] nxt_byte = (nxt_phase == PH_ADDR) ? addr_byte :
		(nxt_phase == PH_MODE) ? mode_q :
		(nxt_phase == PH_DATA && dir_q == DIR_WRITE) ? wr_data_in : 8'h00;
	wire logic [2:0] nxt_w = width_of(nxt_phase, quad_mode_out, aw_q, dw_q);
	wire logic nxt_drv = !(nxt_phase == PH_DATA && dir_q == DIR_READ) &&
		!(nxt_phase == PH_DUMMY && nxt_w != W1);
	wire logic cur_drv = !(phase_q == PH_DATA && dir_q == DIR_READ) &&
		!(phase_q == PH_DUMMY && cur_w != W1);
	wire logic [7:0] nxt_pins = (nxt_phase == PH_END) ? PINS_IDLE :
		pins(nxt_byte, nxt_w, nxt_drv);
	// next lower bits move to the top
	wire logic [7:0] tx_shift = tx_q << cur_w;
	wire logic [7:0] cur_pins = pins(tx_shift, cur_w, cur_drv);
	wire logic [7:0] start_pins = pins(opcode_in,
		quad_mode_out ? W4 : W1, 1'b1);
	wire logic [7:0] rx_next = (cur_w == W4) ? {rx_q[3:0], sync2_q} :
		(cur_w == W2) ? {rx_q[5:0], sync2_q[1:0]} : {rx_q[6:0], sync2_q[1]};

	state_t state_d;
	assign state_d = (state_q == ST_IDLE) ? (start ? ST_SHIFT : ST_IDLE) :
		(state_q == ST_SHIFT) ? (frame_end ? ST_GAP : ST_SHIFT) :
		(gap_q == 2'(CS_HIGH_CYC - 1)) ? ST_IDLE : ST_GAP;

	// pin input synchroniser
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= sio_in;
			sync2_q <= sync1_q;
		end
	end

	// frame state and deselect gap
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= ST_IDLE;
			ready_out <= 1'b0;
			gap_q <= 2'h0;
		end else begin
			state_q <= state_d;
			ready_out <= state_d == ST_IDLE;
			gap_q <= (state_q == ST_GAP) ? gap_q + 2'h1 : 2'h0;
		end
	end

	// shift clock divider, idle low
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_q <= 3'h0;
			sclk_out <= 1'b0;
		end else begin
			div_q <= (state_q == ST_SHIFT && !tick) ? div_q + 3'h1 : 3'h0;
			if (rise)
				sclk_out <= 1'b1;
			else if (fall)
				sclk_out <= 1'b0;
		end
	end

	// request capture
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			op_q <= 8'h00;
			addr_q <= 24'h000000;
			mode_q <= 8'h00;
			len_q <= 16'h0000;
			n_addr_q <= 2'h0;
			n_dummy_q <= 2'h0;
			has_mode_q <= 1'b0;
			needs_latch_q <= 1'b0;
			dir_q <= DIR_NONE;
			aw_q <= W1;
			dw_q <= W1;
		end else if (start) begin
			op_q <= opcode_in;
			addr_q <= addr_in;
			mode_q <= mode_in;
			len_q <= len_in;
			n_addr_q <= bare_rdp ? 2'h0 : f_n_addr;
			n_dummy_q <= f_n_dummy;
			has_mode_q <= f_mode;
			needs_latch_q <= f_latch;
			dir_q <= bare_rdp ? DIR_NONE : f_dir;
			aw_q <= f_aw;
			dw_q <= f_dw;
		end
	end

	// bit shifting; data changes at frame start and on falling edges
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cs_n_out <= 1'b1;
			phase_q <= PH_END;
			cnt_q <= 16'h0000;
			bitc_q <= 3'h0;
			tx_q <= 8'h00;
			{sio_oe_out, sio_out} <= PINS_IDLE;
		end else if (start) begin
			cs_n_out <= 1'b0;
			phase_q <= PH_OP;
			cnt_q <= 16'h0000;
			bitc_q <= 3'h0;
			tx_q <= opcode_in;
			{sio_oe_out, sio_out} <= start_pins;
		end else if (byte_end) begin
			// select rises only on a byte end
			cs_n_out <= nxt_phase == PH_END;
			phase_q <= nxt_phase;
			cnt_q <= nxt_cnt;
			bitc_q <= 3'h0;
			tx_q <= nxt_byte;
			{sio_oe_out, sio_out} <= nxt_pins;
		end else if (fall) begin
			// new bits settle before next rise
			bitc_q <= bitc_q + 3'h1;
			tx_q <= tx_shift;
			{sio_oe_out, sio_out} <= cur_pins;
		end
	end

	// read capture at rising edges and bit tally
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_q <= 8'h00;
			bits_q <= 3'h0;
		end else if (start) begin
			bits_q <= 3'h0;
		end else if (rise) begin
			rx_q <= rx_next;
			bits_q <= bits_q + cur_w;
		end
	end

	// user strobes
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= 8'h00;
			wr_take_out <= 1'b0;
			done_out <= 1'b0;
			reject_out <= 1'b0;
		end else begin
			// host ends reads after len bytes
			rd_valid_out <= byte_end && phase_q == PH_DATA &&
				dir_q == DIR_READ;
			if (byte_end)
				rd_data_out <= rx_q;
			wr_take_out <= byte_end && nxt_phase == PH_DATA &&
				dir_q == DIR_WRITE;
			done_out <= frame_end;
			reject_out <= state_q == ST_IDLE && req_in && refuse;
		end
	end

	// shadow of device modes, updated as each frame completes
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			write_latch_flag_q <= 1'b0;
			dpd_q <= 1'b0;
			arm_q <= 1'b0;
			quad_mode_out <= 1'b0;
		end else if (frame_end) begin
			if (op_q == OP_WR_EN || op_q == OP_VOL_EN)
				write_latch_flag_q <= 1'b1;
			else if (op_q == OP_WR_DIS || needs_latch_q || op_q == OP_RST)
				write_latch_flag_q <= 1'b0;
			dpd_q <= (op_q == OP_DPD) || (dpd_q && op_q != OP_RDP);
			arm_q <= op_q == OP_RST_EN;
			if (op_q == OP_QUAD_ON)
				quad_mode_out <= 1'b1;
			else if (op_q == OP_QUAD_OFF || op_q == OP_RST)
				quad_mode_out <= 1'b0;
		end
	end

	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence s_high_half;
		sclk_out [*4];
	endsequence
	sequence s_then_low;
		!sclk_out;
	endsequence

	AST_CLK_IN_FRAME: assert property (
		$rose(sclk_out) |-> !cs_n_out)
		else $error("shift clock rose while deselected");
	AST_MSB_FIRST: assert property (
		$fell(cs_n_out) && !quad_mode_out |-> sio_out[0] == op_q[7])
		else $error("opcode msb not first on serial input");
	AST_STABLE_AT_RISE: assert property (
		$rose(sclk_out) |-> $stable(sio_out) && $stable(sio_oe_out))
		else $error("data pins moved at rising edge");
	AST_HALF_PERIOD: assert property (
		$rose(sclk_out) |-> s_high_half ##1 s_then_low)
		else $error("shift clock high phase wrong length");
	AST_OP_FIRST: assert property (
		$fell(cs_n_out) |-> phase_q == PH_OP && bitc_q == 3'h0)
		else $error("frame did not open with opcode");
	AST_DONE_DESELECT: assert property (
		done_out |-> cs_n_out && !$past(cs_n_out))
		else $error("done without select rising");
	AST_CS_GAP: assert property (
		$rose(cs_n_out) |-> cs_n_out [*4])
		else $error("deselect gap too short");
	AST_READ_PULSE: assert property (
		rd_valid_out |-> dir_q == DIR_READ ##1 !rd_valid_out)
		else $error("bad read strobe");
	AST_BYTE_BOUND: assert property (
		$rose(cs_n_out) |-> bits_q == 3'h0)
		else $error("select rose off a byte boundary");
	AST_DPD_GATE: assert property (
		$fell(cs_n_out) && dpd_q |-> op_q == OP_RDP)
		else $error("command sent during deep power-down");
	AST_LATCH_GATE: assert property (
		$fell(cs_n_out) && needs_latch_q |-> write_latch_flag_q)
		else $error("modifying command without write enable");
	AST_RESET_PAIR: assert property (
		$fell(cs_n_out) && op_q == OP_RST |-> arm_q)
		else $error("reset not preceded by reset enable");

endmodule

// *** design/sflash_host_pkg.sv ***
package sflash_host_pkg;

	// single-byte operation codes sent first in every frame
	localparam logic [7:0] OP_WR_EN = 8'h06;
	localparam logic [7:0] OP_WR_DIS = 8'h04;
	localparam logic [7:0] OP_VOL_EN = 8'h50;
	localparam logic [7:0] OP_RD_SR1 = 8'h05;
	localparam logic [7:0] OP_RD_SR2 = 8'h35;
	localparam logic [7:0] OP_RD_CR_A = 8'h45;
	localparam logic [7:0] OP_RD_CR_B = 8'h15;
	localparam logic [7:0] OP_WR_SR = 8'h01;
	localparam logic [7:0] OP_WR_SR2 = 8'h31;
	localparam logic [7:0] OP_WR_CR = 8'h11;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_FAST_D = 8'h3B;
	localparam logic [7:0] OP_FAST_Q = 8'h6B;
	localparam logic [7:0] OP_WORD_Q = 8'hE7;
	localparam logic [7:0] OP_OCT_Q = 8'hE3;
	localparam logic [7:0] OP_IO_D = 8'hBB;
	localparam logic [7:0] OP_IO_Q = 8'hEB;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_PROG_D = 8'hA2;
	localparam logic [7:0] OP_PROG_Q = 8'h32;
	localparam logic [7:0] OP_ER_PAGE = 8'h81;
	localparam logic [7:0] OP_ER_SECT = 8'h20;
	localparam logic [7:0] OP_ER_32K = 8'h52;
	localparam logic [7:0] OP_ER_64K = 8'hD8;
	localparam logic [7:0] OP_ER_CHIP_A = 8'hC7;
	localparam logic [7:0] OP_ER_CHIP_B = 8'h60;
	localparam logic [7:0] OP_ID_MD = 8'h90;
	localparam logic [7:0] OP_ID_MD_D = 8'h92;
	localparam logic [7:0] OP_ID_MD_Q = 8'h94;
	localparam logic [7:0] OP_ID_JED = 8'h9F;
	localparam logic [7:0] OP_UID = 8'h4B;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_SUSP_A = 8'h75;
	localparam logic [7:0] OP_SUSP_B = 8'hB0;
	localparam logic [7:0] OP_RESUME_A = 8'h7A;
	localparam logic [7:0] OP_RESUME_B = 8'h30;
	localparam logic [7:0] OP_DPD = 8'hB9;
	localparam logic [7:0] OP_RDP = 8'hAB;
	localparam logic [7:0] OP_QUAD_ON = 8'h38;
	localparam logic [7:0] OP_QUAD_OFF = 8'hFF;

	// lane counts of a phase, and the address byte count
	localparam logic [2:0] W1 = 3'h1;
	localparam logic [2:0] W2 = 3'h2;
	localparam logic [2:0] W4 = 3'h4;
	localparam logic [1:0] ADDR_BYTES = 2'h3;

	// pins between frames: hold and protect lines driven high
	localparam logic [7:0] PINS_IDLE = 8'hCC;

	// timing
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned SCLK_HALF_NS = 160;
	localparam int unsigned SCLK_HALF_CYC = SCLK_HALF_NS / CLK_PERIOD_NS;
	localparam int unsigned CS_HIGH_NS = 100;
	localparam int unsigned CS_HIGH_CYC =
		(CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		DIR_NONE = 2'h0,
		DIR_READ = 2'h1,
		DIR_WRITE = 2'h2
	} dir_t;

	typedef enum logic [2:0] {
		PH_OP = 3'h0,
		PH_ADDR = 3'h1,
		PH_MODE = 3'h2,
		PH_DUMMY = 3'h3,
		PH_DATA = 3'h4,
		PH_END = 3'h5
	} phase_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SHIFT = 2'h1,
		ST_GAP = 2'h2
	} state_t;

endpackage

// *** design/sflash_op_format.sv ***
module sflash_op_format import sflash_host_pkg::*; (
	input wire logic [7:0] opcode_in,
	output logic known_out,
	output logic needs_latch_out,
	output logic has_mode_out,
	output logic [1:0] n_addr_out,
	output logic [1:0] n_dummy_out,
	output dir_t dir_out,
	output logic [2:0] addr_w_out,
	output logic [2:0] data_w_out
);

	// frame layout of each known operation code
	always_comb begin
		known_out = 1'b1;
		needs_latch_out = 1'b0;
		has_mode_out = 1'b0;
		n_addr_out = 2'h0;
		n_dummy_out = 2'h0;
		dir_out = DIR_NONE;
		addr_w_out = W1;
		data_w_out = W1;
		case (opcode_in)
			OP_WR_EN, OP_WR_DIS, OP_VOL_EN, OP_RST_EN, OP_RST, OP_SUSP_A,
			OP_SUSP_B, OP_RESUME_A, OP_RESUME_B, OP_DPD, OP_QUAD_ON,
			OP_QUAD_OFF: begin
				known_out = 1'b1;
			end
			OP_RD_SR1, OP_RD_SR2, OP_RD_CR_A, OP_RD_CR_B, OP_ID_JED: begin
				dir_out = DIR_READ;
			end
			OP_WR_SR, OP_WR_SR2, OP_WR_CR: begin
				dir_out = DIR_WRITE;
				needs_latch_out = 1'b1;
			end
			OP_READ, OP_ID_MD, OP_RDP: begin
				n_addr_out = ADDR_BYTES;
				dir_out = DIR_READ;
			end
			OP_FAST, OP_FAST_D, OP_FAST_Q, OP_UID: begin
				n_addr_out = ADDR_BYTES;
				n_dummy_out = 2'h1;
				dir_out = DIR_READ;
				data_w_out = (opcode_in == OP_FAST_D) ? W2 :
					(opcode_in == OP_FAST_Q) ? W4 : W1;
			end
			OP_IO_D, OP_ID_MD_D: begin
				n_addr_out = ADDR_BYTES;
				has_mode_out = 1'b1;
				dir_out = DIR_READ;
				addr_w_out = W2;
				data_w_out = W2;
			end
			OP_IO_Q, OP_ID_MD_Q, OP_WORD_Q, OP_OCT_Q: begin
				n_addr_out = ADDR_BYTES;
				has_mode_out = 1'b1;
				n_dummy_out = (opcode_in == OP_WORD_Q) ? 2'h1 :
					(opcode_in == OP_OCT_Q) ? 2'h0 : 2'h2;
				dir_out = DIR_READ;
				addr_w_out = W4;
				data_w_out = W4;
			end
			OP_PROG, OP_PROG_D, OP_PROG_Q: begin
				n_addr_out = ADDR_BYTES;
				dir_out = DIR_WRITE;
				needs_latch_out = 1'b1;
				data_w_out = (opcode_in == OP_PROG_D) ? W2 :
					(opcode_in == OP_PROG_Q) ? W4 : W1;
			end
			OP_ER_PAGE, OP_ER_SECT, OP_ER_32K, OP_ER_64K: begin
				n_addr_out = ADDR_BYTES;
				needs_latch_out = 1'b1;
			end
			OP_ER_CHIP_A, OP_ER_CHIP_B: begin
				needs_latch_out = 1'b1;
			end
			default: begin
				known_out = 1'b0;
			end
		endcase
	end

endmodule

// *** test/sflash_dev_model.sv ***
module sflash_dev_model import sflash_host_pkg::*; #(
	parameter logic [7:0] SR_LO = 8'h5A,
	parameter logic [7:0] SR_HI = 8'hC3,
	parameter logic [7:0] ARR = 8'hA5,
	// arbitrary identifier value
	parameter logic [7:0] ID = 8'h3E,
	// lowest protected address; erases at or above it are ignored
	parameter logic [23:0] PROT_BASE = 24'hF00000
) (
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic [3:0] sio_in,
	output logic [3:0] sio_out,
	output logic [3:0] sio_oe_out,
	output int bits_out,
	output logic [7:0] op_out,
	output logic [63:0] rx_out,
	output logic latch_out,
	output logic pd_out,
	output int erase_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int pre;
	int w;
	int idx;
	int ln;
	logic [7:0] ob;
	logic [3:0] drv;
	logic [3:0] val;

	// lanes and returned byte per opcode
	// output format
	assign w = (op_out inside {OP_FAST_D, OP_IO_D}) ? 2 :
		(op_out inside {OP_FAST_Q, OP_IO_Q, OP_WORD_Q, OP_OCT_Q}) ? 4 : 1;
	assign ob = (op_out == OP_RD_SR1) ? SR_LO :
		(op_out == OP_RD_SR2) ? SR_HI :
		(op_out inside {OP_ID_JED, OP_ID_MD, OP_RDP, OP_UID}) ? ID : ARR;

	// clocks before output data starts
	// phase lengths
	always_comb begin
		case (op_out)
			OP_RD_SR1, OP_RD_SR2, OP_ID_JED: pre = 8;
			OP_OCT_Q: pre = 16;
			OP_WORD_Q: pre = 18;
			OP_IO_Q: pre = 20;
			OP_IO_D: pre = 24;
			OP_READ, OP_ID_MD, OP_RDP: pre = 32;
			OP_FAST, OP_FAST_D, OP_FAST_Q, OP_UID: pre = 40;
			default: pre = -1;
		endcase
	end

	initial begin
		sio_out = 4'h0;
		sio_oe_out = 4'h0;
		bits_out = 0;
		op_out = 8'h00;
		latch_out = 1'b0;
		pd_out = 1'b0;
		erase_out = 0;
	end

	// new frame on select fall
	always @(negedge cs_n_in) begin
		bits_out = 0;
		idx = 0;
	end

	always @(posedge sclk_in) begin
		if (!cs_n_in && bits_out < 8)
			op_out <= {op_out[6:0], sio_in[0]};
		else if (!cs_n_in)
			rx_out <= {rx_out[62:0], sio_in[0]};
		if (!cs_n_in)
			bits_out <= bits_out + 1;
	end

	// released lanes flip so stale data never reads back
	// data on falling clock
	always @(negedge sclk_in) begin
		drv = 4'h0;
		val = ~sio_out;
		if (!cs_n_in && pre >= 0 && bits_out >= pre) begin
			for (int j = 0; j < w; j++) begin
				ln = (w == 1) ? 1 : j;
				drv[ln] = 1'b1;
				val[ln] = ob[7 - idx - (w - 1 - j)];
			end
			idx = (idx + w) % 8;
		end
		sio_oe_out <= drv;
		sio_out <= val;
	end

	always @(posedge cs_n_in) begin
		sio_oe_out <= 4'h0;
		sio_out <= ~sio_out;
		if (bits_out % 8 == 0 && (!pd_out || op_out == OP_RDP)) begin
			if (op_out inside {OP_WR_EN, OP_VOL_EN})
				latch_out <= 1'b1;
			else if (op_out inside {OP_WR_DIS, OP_PROG, OP_PROG_D,
				OP_PROG_Q, OP_ER_PAGE, OP_ER_SECT, OP_ER_32K, OP_ER_64K,
				OP_ER_CHIP_A, OP_ER_CHIP_B, OP_WR_SR, OP_WR_SR2, OP_WR_CR})
				latch_out <= 1'b0;
			// erases reaching the protected top are ignored
			if (latch_out && rx_out[23:0] < PROT_BASE && op_out inside
				{OP_ER_PAGE, OP_ER_SECT, OP_ER_32K, OP_ER_64K})
				erase_out <= erase_out + 1;
			pd_out <= (op_out == OP_DPD) ? 1'b1 :
				(op_out == OP_RDP) ? 1'b0 : pd_out;
		end
	end
endmodule

// *** test/tb.sv ***
module tb import sflash_host_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] SR_LO = 8'h5A;
	localparam logic [7:0] SR_HI = 8'hC3;
	localparam logic [7:0] ARR = 8'hA5;
	// arbitrary identifier value
	localparam logic [7:0] ID = 8'h3E;
	localparam logic [23:0] PROT = 24'hF00000;
	logic clk, rst_n, req, ready, wtake, rvld, done, rej, quad, cs_n, sclk;
	logic [7:0] op, wdat, rdat, mop, mode;
	logic [23:0] addr;
	logic [15:0] len;
	logic [3:0] h_sio, h_oe, d_sio, d_oe, line;
	logic [63:0] rx;
	logic latch, pd;
	int bits, ers, error_cnt, cmp_count;

	// pin level from the host's enables; the device drives any lane the host releases
	assign line = (h_oe & h_sio) | (~h_oe & d_sio);

	sflash_host_ctrl u_dut (
		.ref_clk_in(clk), .arst_n_in(rst_n), .req_in(req),
		.opcode_in(op), .addr_in(addr), .mode_in(mode), .len_in(len),
		.wr_data_in(wdat), .ready_out(ready), .wr_take_out(wtake),
		.rd_data_out(rdat), .rd_valid_out(rvld), .done_out(done),
		.reject_out(rej), .quad_mode_out(quad), .cs_n_out(cs_n),
		.sclk_out(sclk), .sio_out(h_sio), .sio_oe_out(h_oe),
		.sio_in(line)
	);

	sflash_dev_model #(.SR_LO(SR_LO), .SR_HI(SR_HI), .ARR(ARR), .ID(ID),
		.PROT_BASE(PROT))
	u_dev (
		.cs_n_in(cs_n), .sclk_in(sclk), .sio_in(line), .sio_out(d_sio),
		.sio_oe_out(d_oe), .bits_out(bits), .op_out(mop), .rx_out(rx),
		.latch_out(latch), .pd_out(pd), .erase_out(ers)
	);

	always #20 clk = ~clk;

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one request, followed to its end or refusal
	task automatic run(input logic [7:0] o, input logic [23:0] a,
		input logic [15:0] n, input int b, input logic [7:0] x,
		input logic r);
		int nr;
		logic sr;
		logic fin;
		nr = 0;
		sr = 0;
		fin = 0;
		// let an edge pass so a refused request is seen low
		@(posedge clk);
		#1;
		repeat (50) if (ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		req = 1;
		op = o;
		addr = a;
		len = n;
		wdat = 8'h3C;
		@(posedge clk);
		#1;
		req = 0;
		repeat (3000) begin
			if (rej === 1'b1)
				sr = 1;
			if (wtake === 1'b1)
				wdat = wdat + 8'h01;
			if (rvld === 1'b1) begin
				nr++;
				chk("read byte", x, rdat);
			end
			if (fin || sr)
				break;
			if (done === 1'b1)
				fin = 1;
			@(posedge clk);
			#1;
		end
		chk("ended", 1, fin | sr);
		chk("refused", r, sr);
		if (!r) begin
			chk("frame clocks", b, bits);
			chk("read count", x ? {16'h0, n} : 32'h0, nr);
		end
	endtask

	task automatic t_status();
		run(OP_RD_SR1, 24'h0, 16'h2, 24, SR_LO, 0);
		run(OP_RD_SR2, 24'h0, 16'h1, 16, SR_HI, 0);
	endtask

	task automatic t_read();
		run(OP_READ, 24'h123456, 16'h1, 40, ARR, 0);
		chk("address", 32'h123456, rx[31:8]);
		run(OP_FAST, 24'h0, 16'h1, 48, ARR, 0);
		run(OP_FAST_D, 24'h0, 16'h2, 48, ARR, 0);
		run(OP_FAST_Q, 24'h0, 16'h2, 44, ARR, 0);
	endtask

	task automatic t_multi();
		run(OP_IO_D, 24'h0, 16'h1, 28, ARR, 0);
		chk("mode on io0", {mode[6], mode[4], mode[2], mode[0]}, rx[7:4]);
		run(OP_IO_Q, 24'h0, 16'h1, 22, ARR, 0);
		run(OP_WORD_Q, 24'h0, 16'h1, 20, ARR, 0);
		run(OP_OCT_Q, 24'h0, 16'h1, 18, ARR, 0);
	endtask

	task automatic t_id();
		run(OP_ID_JED, 24'h0, 16'h3, 32, ID, 0);
		run(OP_ID_MD, 24'h0, 16'h2, 48, ID, 0);
		run(OP_UID, 24'h0, 16'h1, 48, ID, 0);
	endtask

	task automatic t_write();
		run(OP_PROG, 24'h000100, 16'h2, 0, 8'h00, 1);
		run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		chk("latch set", 1, latch);
		run(OP_PROG, 24'h000100, 16'h2, 48, 8'h00, 0);
		chk("program data", 32'h3C3D, rx[15:0]);
		chk("latch used", 0, latch);
	endtask

	task automatic t_regs();
		run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_WR_SR, 24'h0, 16'h2, 24, 8'h00, 0);
		run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_WR_SR2, 24'h0, 16'h1, 16, 8'h00, 0);
		run(OP_VOL_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_WR_CR, 24'h0, 16'h1, 16, 8'h00, 0);
		run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_WR_DIS, 24'h0, 16'h0, 8, 8'h00, 0);
		chk("latch cleared", 0, latch);
	endtask

	task automatic t_erase();
		logic [7:0] e [6];
		e = '{OP_ER_PAGE, OP_ER_SECT, OP_ER_32K, OP_ER_64K,
			OP_ER_CHIP_A, OP_ER_CHIP_B};
		foreach (e[i]) begin
			run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
			run(e[i], 24'h001000, 16'h0, (i < 4) ? 32 : 8, 8'h00, 0);
		end
		chk("erases done", 4, ers);
		run(OP_WR_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_ER_SECT, PROT, 16'h0, 32, 8'h00, 0);
		chk("protected erase", 4, ers);
	endtask

	task automatic t_pd();
		run(OP_DPD, 24'h0, 16'h0, 8, 8'h00, 0);
		chk("power down", 1, pd);
		run(OP_RD_SR1, 24'h0, 16'h1, 0, 8'h00, 1);
		run(OP_RDP, 24'h0, 16'h0, 8, 8'h00, 0);
		chk("power up", 0, pd);
		run(OP_RDP, 24'h0, 16'h1, 40, ID, 0);
	endtask

	task automatic t_misc();
		run(OP_RST, 24'h0, 16'h0, 0, 8'h00, 1);
		run(OP_RST_EN, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_RST, 24'h0, 16'h0, 8, 8'h00, 0);
		run(8'h25, 24'h0, 16'h0, 0, 8'h00, 1);
		run(OP_SUSP_A, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_RESUME_B, 24'h0, 16'h0, 8, 8'h00, 0);
		run(OP_QUAD_ON, 24'h0, 16'h0, 8, 8'h00, 0);
		chk("quad on", 1, quad);
		run(OP_QUAD_OFF, 24'h0, 16'h0, 2, 8'h00, 0);
		chk("quad off", 0, quad);
	endtask

	// reset, then every scenario in turn
	initial begin
		clk = 0;
		rst_n = 0;
		req = 0;
		op = 8'h00;
		addr = 24'h0;
		len = 16'h0;
		wdat = 8'h00;
		mode = 8'h5A;
		error_cnt = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1;
		repeat (2) @(posedge clk);
		#1;
		t_status();
		t_read();
		t_multi();
		t_id();
		t_write();
		t_regs();
		t_erase();
		t_pd();
		t_misc();
		print_verdict();
	end

	// watchdog well beyond the longest run
	initial begin
		#2000000;
		error_cnt++;
		$display("FAIL watchdog expected end seen timeout");
		print_verdict();
	end
endmodule
